// >>> design/vsg_sync_ctrl.sv
// sync pin direction/polarity, genlock source select and field indicator placement
//
// What this block does
// [R1] line sync pin direction bit 28, polarity 25
// [R2] field pin polarity bit 26 sets field-1 level
// [R3] lock source field 23:21, others reserved
// [R4] no lock: counters wrap on programmed totals
// [R5] master: sync asserts edge after start match
// [R6] master: sync deasserts edge after stop match
// [R7] slave: counter loads start after sync assertion
// [R8] slave: ignore sync trailing edge and stop
// [R9] defaults target 525-line master timing
// [R10] bits 20:11 field-1 switch position
// [R11] bits 10:1 field-2 switch position
// [R12] bit 0 is switch-compare half step
// [R13] delay bits 31:21 reserved, read only
// [R14] field pin direction bit 29
// [R15] run bit 31 low holds field-1 start
// [R16] sync positions doubled plus half step
// [R17] no lock is master, lock modes slave
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module vsg_sync_ctrl
   import vsg_pkg::*;
(
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   // line sync pin
   input  wire logic              line_sync_i,
   output logic                   line_sync_o,
   output logic                   line_sync_oe,
   // field indicator pin
   input  wire logic              field_pin_i,
   output logic                   field_pin_o,
   output logic                   field_pin_oe,
   // timing reference from the embedded-code decoder
   input  wire logic              code_line_start,
   input  wire logic              code_field,
   // counter state
   output logic      [HCNT_W-1:0] h_count,
   output logic      [LINE_W-1:0] line_count,
   output logic                   field_now
);
   vsg_tim_if tif ();

   logic [31:0] sync_ctrl_reg;
   logic [31:0] field_dly_reg;
   logic [31:0] frame_total_reg;

   logic        timing_gen_run;
   logic        field_pin_direction;
   logic        line_sync_direction;
   logic        field_pin_polarity;
   logic        line_sync_polarity;
   logic [2:0]  lock_source_select;
   logic [5:0]  line_sync_start_field;
   logic [7:0]  line_sync_stop_field;
   logic        line_sync_half_step;
   logic [9:0]  field_switch_pos_first;
   logic [9:0]  field_switch_pos_second;
   logic        field_switch_half_step;

   logic [10:0] line_sync_start;
   logic [10:0] line_sync_stop;
   logic [10:0] field_switch_first;
   logic [10:0] field_switch_second;
   logic        master_mode;
   logic        pin_lock;
   logic        code_lock;

   logic [1:0]  hs_sync;
   logic [1:0]  fp_sync;
   logic        hs_prev;
   logic        fp_prev;
   logic        hs_active_in;
   logic        fp_field_in;
   logic        code_field_prev;

   logic        hs_active_reg;
   logic        hs_active_next;
   logic        field_ind_reg;
   logic        field_ind_next;

   // shared readback decode
   function automatic logic [31:0] reg_view(input logic [7:0] addr, input logic [31:0] ctrl,
                                            input logic [31:0] dly, input logic [31:0] tot);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (addr)
         OFS_SYNC_CTRL:   v = ctrl & SYNC_CTRL_MASK;
         OFS_FIELD_DLY:   v = dly & FIELD_DLY_MASK; // [R13]
         OFS_FRAME_TOTAL: v = tot & FRAME_TOTAL_MASK;
         default:         v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // register field split
   assign timing_gen_run          = sync_ctrl_reg[RUN_BIT];
   assign field_pin_direction     = sync_ctrl_reg[FDIR_BIT];
   assign line_sync_direction     = sync_ctrl_reg[HDIR_BIT];
   assign field_pin_polarity      = sync_ctrl_reg[FPOL_BIT];
   assign line_sync_polarity      = sync_ctrl_reg[HPOL_BIT];
   assign lock_source_select      = sync_ctrl_reg[MODE_HI:MODE_LO];
   assign line_sync_start_field   = sync_ctrl_reg[SST_HI:SST_LO];
   assign line_sync_stop_field    = sync_ctrl_reg[SSP_HI:SSP_LO];
   assign line_sync_half_step     = sync_ctrl_reg[HSTEP_BIT];
   assign field_switch_pos_first  = field_dly_reg[FSW1_HI:FSW1_LO];
   assign field_switch_pos_second = field_dly_reg[FSW2_HI:FSW2_LO];
   assign field_switch_half_step  = field_dly_reg[FSTEP_BIT];

   // pixel positions doubled, half step as lsb
   assign line_sync_start     = {4'h0, line_sync_start_field, line_sync_half_step}; // [R16]
   assign line_sync_stop      = {2'h0, line_sync_stop_field, line_sync_half_step}; // [R16]
   assign field_switch_first  = {field_switch_pos_first, field_switch_half_step}; // [R10] [R12]
   assign field_switch_second = {field_switch_pos_second, field_switch_half_step}; // [R11] [R12]

   // reserved codes fall back to free running, the safest choice for an unlocked source
   assign pin_lock    = (lock_source_select == LOCK_PINS); // [R3]
   assign code_lock   = (lock_source_select == LOCK_CODES); // [R3]
   assign master_mode = !(pin_lock || code_lock); // [R17]

   // register port
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sync_ctrl_reg <= SYNC_CTRL_RST; // [R9]
      end else if (reg_wr && reg_addr == OFS_SYNC_CTRL) begin
         sync_ctrl_reg <= reg_wdata & SYNC_CTRL_MASK;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         field_dly_reg <= FIELD_DLY_RST;
      end else if (reg_wr && reg_addr == OFS_FIELD_DLY) begin
         field_dly_reg <= reg_wdata & FIELD_DLY_MASK; // [R13]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         frame_total_reg <= FRAME_TOTAL_RST; // [R9]
      end else if (reg_wr && reg_addr == OFS_FRAME_TOTAL) begin
         frame_total_reg <= reg_wdata & FRAME_TOTAL_MASK;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !reg_rd) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= reg_view(reg_addr, sync_ctrl_reg, field_dly_reg, frame_total_reg);
      end
   end

   // pin synchronisers
   // pins idle high: starting the stages there avoids a false edge after reset
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         hs_sync <= 2'h3;
         fp_sync <= 2'h3;
      end else begin
         hs_sync <= {hs_sync[0], line_sync_i};
         fp_sync <= {fp_sync[0], field_pin_i};
      end
   end

   // normalise to active high / field-2 high
   assign hs_active_in = hs_sync[1] ~^ line_sync_polarity; // [R1]
   assign fp_field_in  = fp_sync[1] ^ field_pin_polarity; // [R2]

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         hs_prev         <= 1'b0;
         fp_prev         <= 1'b1;
         code_field_prev <= 1'b0;
      end else begin
         hs_prev         <= hs_active_in;
         fp_prev         <= fp_field_in;
         code_field_prev <= code_field;
      end
   end

   // counter control
   // only the leading edge of the input sync reloads the counter; its trailing edge is unused
   always_comb begin
      tif.run          = timing_gen_run; // [R15]
      tif.h_total      = frame_total_reg[HTOT_HI:HTOT_LO];
      tif.v_total      = frame_total_reg[VTOT_HI:VTOT_LO];
      tif.h_load_val   = line_sync_start; // [R7]
      tif.h_load       = 1'b0;
      tif.v_load       = 1'b0;
      tif.v_load_field = 1'b0;
      if (pin_lock && !line_sync_direction) begin
         tif.h_load = hs_active_in && !hs_prev; // [R7] [R8]
         // two sync stages cost two edges; loading one past start keeps the second-edge alignment
         tif.h_load_val = line_sync_start + 11'h001; // [R7]
      end else if (code_lock) begin
         tif.h_load = code_line_start;
      end
      if (pin_lock && !field_pin_direction) begin
         tif.v_load       = fp_field_in ^ fp_prev;
         tif.v_load_field = fp_field_in;
      end else if (code_lock) begin
         tif.v_load       = code_field ^ code_field_prev;
         tif.v_load_field = code_field;
      end
   end

   vsg_timing_counter u_counter (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .tif     (tif)
   );

   // line sync generation
   always_comb begin
      hs_active_next = hs_active_reg;
      if (!master_mode || !timing_gen_run) begin
         hs_active_next = 1'b0; // [R8]
      end else if (tif.h_cnt == line_sync_start) begin
         hs_active_next = 1'b1; // [R5]
      end else if (tif.h_cnt == line_sync_stop) begin
         hs_active_next = 1'b0; // [R6]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         hs_active_reg <= 1'b0;
      end else begin
         hs_active_reg <= hs_active_next;
      end
   end

   // pin level registered with the state so the edge lands one clock after the match
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         line_sync_o  <= 1'b1;
         line_sync_oe <= 1'b0;
      end else begin
         line_sync_o  <= hs_active_next ~^ line_sync_polarity; // [R1]
         line_sync_oe <= line_sync_direction; // [R1]
      end
   end

   // field indicator
   // the indicator follows the counter field, switching on line 0 at the programmed position
   always_comb begin
      field_ind_next = field_ind_reg;
      if (!timing_gen_run) begin
         field_ind_next = 1'b0; // [R15]
      end else if (tif.field != field_ind_reg && tif.v_cnt == 10'h000) begin
         if (tif.field && tif.h_cnt == field_switch_first) begin
            field_ind_next = 1'b1; // [R10]
         end else if (!tif.field && tif.h_cnt == field_switch_second) begin
            field_ind_next = 1'b0; // [R11]
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         field_ind_reg <= 1'b0;
      end else begin
         field_ind_reg <= field_ind_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         field_pin_o  <= 1'b0;
         field_pin_oe <= 1'b0;
      end else begin
         field_pin_o  <= field_ind_next ^ field_pin_polarity; // [R2]
         field_pin_oe <= field_pin_direction; // [R14]
      end
   end

   // counter state exported through flops
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         h_count    <= 11'h000;
         line_count <= 10'h000;
         field_now  <= 1'b0;
      end else begin
         h_count    <= tif.h_cnt;
         line_count <= tif.v_cnt;
         field_now  <= tif.field;
      end
   end

   // checks
   a_sync_rise: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R5]
      master_mode && timing_gen_run && tif.h_cnt == line_sync_start
      |=> line_sync_o == $past(line_sync_polarity))
      else $error("line sync not asserted after start match");

   a_sync_fall: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R6]
      master_mode && timing_gen_run && tif.h_cnt == line_sync_stop && tif.h_cnt != line_sync_start
      |=> line_sync_o != $past(line_sync_polarity))
      else $error("line sync not released after stop match");

   a_slave_load: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R7]
      pin_lock && !line_sync_direction && timing_gen_run && $rose(hs_active_in) && $past(timing_gen_run)
      |=> tif.h_cnt == line_sync_start + 11'h001)
      else $error("slave reload did not take the start value");

   a_slave_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R8]
      !master_mode ##1 !master_mode |-> line_sync_o != $past(line_sync_polarity))
      else $error("line sync driven active in slave mode");

   a_pin_dirs: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R14]
      ##1 line_sync_oe == $past(line_sync_direction) && field_pin_oe == $past(field_pin_direction))
      else $error("pin enable does not follow direction bit");

   a_field_level: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R2]
      ##1 field_pin_o == (field_ind_reg ^ $past(field_pin_polarity)))
      else $error("field pin level wrong for polarity");

   a_field_switch: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R10]
      timing_gen_run && tif.field && !field_ind_reg && tif.v_cnt == 10'h000
      && tif.h_cnt == field_switch_first |=> field_ind_reg)
      else $error("field indicator missed the first switch point");

   a_delay_read: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R13]
      reg_rd && reg_addr == OFS_FIELD_DLY |=> reg_rdata[31:21] == 11'h000
      && reg_rdata[20:0] == $past(field_dly_reg[20:0]))
      else $error("field delay readback wrong");
endmodule
`default_nettype wire

// >>> design/vsg_timing_counter.sv
// horizontal, vertical and field counters of the timing generator
`timescale 1ns/100ps
`default_nettype none
module vsg_timing_counter
   import vsg_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   // counter state and loads
   vsg_tim_if.cnt    tif
);
   logic [10:0] h_last;
   logic [9:0]  v_last;
   logic        h_wrap;

   // video clock is twice the pixel rate: a line spans 2*total clocks
   assign h_last = {tif.h_total, 1'b0} - 11'h001;
   assign v_last = tif.v_total - 10'h001;
   assign h_wrap = (tif.h_cnt == h_last);

   always_ff @(posedge sys_clk) begin
      if (sys_rst || !tif.run) begin
         tif.h_cnt <= 11'h000; // [R15]
      end else if (tif.h_load) begin
         tif.h_cnt <= tif.h_load_val; // [R7]
      end else if (h_wrap) begin
         tif.h_cnt <= 11'h000; // [R4]
      end else begin
         tif.h_cnt <= tif.h_cnt + 11'h001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || !tif.run) begin
         tif.v_cnt <= 10'h000; // [R15]
         tif.field <= 1'b0;
      end else if (tif.v_load) begin
         tif.v_cnt <= 10'h000;
         tif.field <= tif.v_load_field;
      end else if (h_wrap && !tif.h_load) begin
         if (tif.v_cnt == v_last) begin
            tif.v_cnt <= 10'h000; // [R4]
            tif.field <= ~tif.field;
         end else begin
            tif.v_cnt <= tif.v_cnt + 10'h001;
         end
      end
   end

   a_hold_stopped: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !tif.run |=> (tif.h_cnt == 11'h000) && (tif.v_cnt == 10'h000) && !tif.field) // [R15]
      else $error("counters not held while stopped");

   a_line_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst)
      tif.run && h_wrap && !tif.h_load && $past(tif.run) |=> tif.h_cnt == 11'h000) // [R4]
      else $error("horizontal counter missed its wrap");
endmodule
`default_nettype wire

// >>> shared/vsg_pkg.sv
// package: register map, field layout and reset values of the sync and genlock control
package vsg_pkg;
   // bus and counter widths
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned HPIX_W = 10;
   localparam int unsigned HCNT_W = 11;
   localparam int unsigned LINE_W = 10;

   // register offsets (byte addresses)
   localparam logic [7:0] OFS_SYNC_CTRL   = 8'h28;
   localparam logic [7:0] OFS_FIELD_DLY   = 8'h2C;
   localparam logic [7:0] OFS_FRAME_TOTAL = 8'h30;

   // sync control field positions
   localparam int unsigned RUN_BIT   = 31;
   localparam int unsigned FDIR_BIT  = 29;
   localparam int unsigned HDIR_BIT  = 28;
   localparam int unsigned FPOL_BIT  = 26;
   localparam int unsigned HPOL_BIT  = 25;
   localparam int unsigned MODE_HI   = 23;
   localparam int unsigned MODE_LO   = 21;
   localparam int unsigned SST_HI    = 17;
   localparam int unsigned SST_LO    = 12;
   localparam int unsigned SSP_HI    = 8;
   localparam int unsigned SSP_LO    = 1;
   localparam int unsigned HSTEP_BIT = 0;

   // field indicator delay field positions
   localparam int unsigned FSW1_HI   = 20;
   localparam int unsigned FSW1_LO   = 11;
   localparam int unsigned FSW2_HI   = 10;
   localparam int unsigned FSW2_LO   = 1;
   localparam int unsigned FSTEP_BIT = 0;

   // frame total field positions
   localparam int unsigned HTOT_HI = 9;
   localparam int unsigned HTOT_LO = 0;
   localparam int unsigned VTOT_HI = 25;
   localparam int unsigned VTOT_LO = 16;

   // implemented bits; all others read as zero
   localparam logic [31:0] SYNC_CTRL_MASK   = 32'hB6E3_F1FF;
   localparam logic [31:0] FIELD_DLY_MASK   = 32'h001F_FFFF;
   localparam logic [31:0] FRAME_TOTAL_MASK = 32'h03FF_03FF;

   // reset values
   localparam logic [31:0] SYNC_CTRL_RST   = 32'h0000_0020;
   localparam logic [31:0] FIELD_DLY_RST   = 32'h0000_0000;
   localparam logic [31:0] FRAME_TOTAL_RST = 32'h020D_035A;

   // lock source codes
   localparam logic [2:0] LOCK_NONE  = 3'h0;
   localparam logic [2:0] LOCK_PINS  = 3'h1;
   localparam logic [2:0] LOCK_CODES = 3'h2;
endpackage

// >>> shared/vsg_tim_if.sv
// interface: horizontal/vertical counter state and load requests
`timescale 1ns/100ps
`default_nettype none
interface vsg_tim_if;
   logic              run;
   logic [10:0]       h_cnt;
   logic [9:0]        v_cnt;
   logic              field;
   logic              h_load;
   logic [10:0]       h_load_val;
   logic              v_load;
   logic              v_load_field;
   logic [9:0]        h_total;
   logic [9:0]        v_total;

   modport ctl (output run, h_load, h_load_val, v_load, v_load_field, h_total, v_total,
                input  h_cnt, v_cnt, field);
   modport cnt (input  run, h_load, h_load_val, v_load, v_load_field, h_total, v_total,
                output h_cnt, v_cnt, field);
endinterface
`default_nettype wire

// >>> verif/vsg_sync_ctrl_tb.sv
// testbench: registers, sync pin generation, genlock loading and field indicator
`timescale 1ns/100ps
`default_nettype none
module vsg_sync_ctrl_tb
   import vsg_pkg::*;
;
   logic              sys_clk;
   logic              sys_rst;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic [DATA_W-1:0] reg_rdata;
   logic [DATA_W-1:0] rd_val;
   logic              reg_wr;
   logic              reg_rd;
   logic              line_sync_o;
   logic              line_sync_oe;
   logic              line_sync_pin;
   logic              field_pin_o;
   logic              field_pin_oe;
   logic              field_pin;
   logic              code_line_start;
   logic              code_field;
   logic [HCNT_W-1:0] h_count;
   logic [LINE_W-1:0] line_count;
   logic              field_now;
   int                fails;
   int                compares;
   logic [2:0]        modes [3] = '{LOCK_NONE, 3'h3, 3'h4};

   initial sys_clk = 1'b0;
   always #25 sys_clk = ~sys_clk;

   vsg_sync_ctrl u_dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .line_sync_i(line_sync_pin), .line_sync_o(line_sync_o), .line_sync_oe(line_sync_oe),
      .field_pin_i(field_pin), .field_pin_o(field_pin_o), .field_pin_oe(field_pin_oe),
      .code_line_start(code_line_start), .code_field(code_field),
      .h_count(h_count), .line_count(line_count), .field_now(field_now)
   );

   vsg_video_peer u_peer (
      .sys_clk(sys_clk), .line_sync_o(line_sync_o), .line_sync_oe(line_sync_oe),
      .field_pin_o(field_pin_o), .field_pin_oe(field_pin_oe),
      .line_sync_pin(line_sync_pin), .field_pin(field_pin)
   );

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out;
      if (fails == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   function automatic logic [31:0] ctl(input logic run, fdir, hdir, fpol, hpol, input logic [2:0] mode,
                                       input logic [5:0] st, input logic [7:0] sp, input logic half);
      ctl = '0;
      ctl[RUN_BIT]         = run;
      ctl[FDIR_BIT]        = fdir;
      ctl[HDIR_BIT]        = hdir;
      ctl[FPOL_BIT]        = fpol;
      ctl[HPOL_BIT]        = hpol;
      ctl[MODE_HI:MODE_LO] = mode;
      ctl[SST_HI:SST_LO]   = st;
      ctl[SSP_HI:SSP_LO]   = sp;
      ctl[HSTEP_BIT]       = half;
   endfunction

   // wait for a counter position; any_line ignores field and line
   task automatic wait_at(input logic f, input logic [9:0] ln, input logic [10:0] h, input logic any_line);
      int n;
      for (n = 0; n < 3000; n++) begin
         @(posedge sys_clk);
         #1;
         if (h_count === h && (any_line || (field_now === f && line_count === ln))) break;
      end
      if (n == 3000) begin
         fails++;
         close_out();
      end
   endtask

   initial begin
      sys_rst         = 1'b1;
      reg_addr        = '0;
      reg_wdata       = '0;
      reg_wr          = 1'b0;
      reg_rd          = 1'b0;
      code_line_start = 1'b0;
      code_field      = 1'b0;
      fails           = 0;
      compares        = 0;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      #1;
      check("line sync oe", 32'(line_sync_oe), 32'h0);
      check("field pin oe", 32'(field_pin_oe), 32'h0);
      reg_read(OFS_SYNC_CTRL, rd_val);
      check("sync ctrl reset", rd_val, 32'h0000_0020);
      reg_read(OFS_FIELD_DLY, rd_val);
      check("field delay reset", rd_val, 32'h0000_0000);
      reg_read(OFS_FRAME_TOTAL, rd_val);
      check("frame total reset", rd_val, 32'h020D_035A);
      check("h count held", 32'(h_count), 32'h0);
      // reserved delay bits are read only and come back zero
      reg_write(OFS_FIELD_DLY, 32'hFFFF_FFFF);
      reg_read(OFS_FIELD_DLY, rd_val);
      check("field delay ones", rd_val, 32'h001F_FFFF);
      reg_write(8'h40, 32'hFFFF_FFFF);
      reg_read(8'h40, rd_val);
      check("unmapped read", rd_val, 32'h0);
      for (int i = 0; i < 8; i++) begin
         reg_write(OFS_SYNC_CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'(i), 6'h00, 8'h00, 1'b0));
         reg_read(OFS_SYNC_CTRL, rd_val);
         check("lock source", rd_val, ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'(i), 6'h00, 8'h00, 1'b0));
      end
      reg_write(OFS_SYNC_CTRL, ctl(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, LOCK_NONE, 6'h00, 8'h00, 1'b0));
      repeat (2) @(posedge sys_clk);
      #1;
      check("line sync oe set", 32'(line_sync_oe), 32'h1);
      check("field pin oe set", 32'(field_pin_oe), 32'h1);
      // master: 20 pixel lines wrap at 39, start 3 odd gives 7, stop 8 odd gives 17
      reg_write(OFS_FRAME_TOTAL, 32'h0002_0014);
      for (int i = 0; i < 3; i++) begin
         reg_write(OFS_SYNC_CTRL, ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'(i == 1 ? 0 : 1), modes[i], 6'h03, 8'h08, 1'b1));
         wait_at(1'b0, 10'h0, 11'h006, 1'b1);
         check("sync before start", 32'(line_sync_pin), 32'(i == 1 ? 1 : 0));
         wait_at(1'b0, 10'h0, 11'h007, 1'b1);
         check("sync at start", 32'(line_sync_pin), 32'(i == 1 ? 0 : 1));
         wait_at(1'b0, 10'h0, 11'h010, 1'b1);
         check("sync before stop", 32'(line_sync_pin), 32'(i == 1 ? 0 : 1));
         wait_at(1'b0, 10'h0, 11'h011, 1'b1);
         check("sync at stop", 32'(line_sync_pin), 32'(i == 1 ? 1 : 0));
         wait_at(1'b0, 10'h0, 11'h027, 1'b1);
         @(posedge sys_clk);
         #1;
         check("h wrap", 32'(h_count), 32'h0);
      end
      // field indicator: first 5 odd switches near 11, second 10 odd near 21
      reg_write(OFS_FIELD_DLY, {11'h000, 10'h005, 10'h00A, 1'b1});
      for (int fp = 0; fp < 2; fp++) begin
         reg_write(OFS_SYNC_CTRL, ctl(1'b1, 1'b1, 1'b1, 1'(fp), 1'b1, LOCK_NONE, 6'h03, 8'h08, 1'b1));
         wait_at(1'b1, 10'h0, 11'h009, 1'b0);
         check("field pin pre f2", 32'(field_pin), 32'(fp));
         wait_at(1'b1, 10'h0, 11'h00F, 1'b0);
         check("field pin in f2", 32'(field_pin), 32'(1 - fp));
         wait_at(1'b0, 10'h0, 11'h012, 1'b0);
         check("field pin pre f1", 32'(field_pin), 32'(1 - fp));
         wait_at(1'b0, 10'h0, 11'h019, 1'b0);
         check("field pin in f1", 32'(field_pin), 32'(fp));
      end
      reg_write(OFS_SYNC_CTRL, ctl(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, LOCK_NONE, 6'h03, 8'h08, 1'b1));
      repeat (3) @(posedge sys_clk);
      #1;
      check("held h", 32'(h_count), 32'h0);
      check("held line", 32'(line_count), 32'h0);
      check("held field", 32'(field_now), 32'h0);
      // pin lock, low true sync: counter sits at start 7 from the second edge, so h_count shows 8 on the fourth
      reg_write(OFS_FRAME_TOTAL, 32'h0002_0028);
      reg_write(OFS_SYNC_CTRL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, LOCK_PINS, 6'h03, 8'h08, 1'b1));
      repeat (20) @(posedge sys_clk);
      fork
         u_peer.send_sync(1'b0, 6);
         begin
            repeat (5) @(posedge sys_clk);
            #1;
            check("slave load", 32'(h_count), 32'h8);
         end
      join
      repeat (3) @(posedge sys_clk);
      #1;
      check("slave run on", 32'(h_count), 32'hE);
      // embedded-code lock: a line start pulse loads 7 at the next edge
      reg_write(OFS_SYNC_CTRL, ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, LOCK_CODES, 6'h03, 8'h08, 1'b1));
      repeat (10) @(posedge sys_clk);
      code_line_start <= 1'b1;
      @(posedge sys_clk);
      code_line_start <= 1'b0;
      @(posedge sys_clk);
      #1;
      check("code load", 32'(h_count), 32'h7);
      check("slave sync idle", 32'(line_sync_pin), 32'h1);
      @(posedge sys_clk);
      code_field <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      check("code field", 32'(field_now), 32'h1);
      close_out();
   end
endmodule
`default_nettype wire

// >>> verif/vsg_video_peer.sv
// far-side video source model: drives the line sync pin and resolves both pin levels
`timescale 1ns/100ps
`default_nettype none
module vsg_video_peer (
   // clock
   input  wire logic sys_clk,
   // device side of the pins
   input  wire logic line_sync_o,
   input  wire logic line_sync_oe,
   input  wire logic field_pin_o,
   input  wire logic field_pin_oe,
   // resolved pin levels
   output logic      line_sync_pin,
   output logic      field_pin
);
   logic sync_en;
   logic sync_val;

   initial begin
      sync_en  = 1'b0;
      sync_val = 1'b1;
   end

   // pins are pulled up, so a released pin never keeps a stale driven level
   assign line_sync_pin = line_sync_oe ? line_sync_o : (sync_en ? sync_val : 1'b1);
   assign field_pin     = field_pin_oe ? field_pin_o : 1'b1;

   // assert sync at the given level for width cycles, show the trailing edge, then release
   task automatic send_sync(input logic active, input int unsigned width);
      @(posedge sys_clk);
      sync_en  <= 1'b1;
      sync_val <= active;
      repeat (width) @(posedge sys_clk);
      sync_val <= ~active;
      @(posedge sys_clk);
      sync_en  <= 1'b0;
   endtask
endmodule
`default_nettype wire
